// >>> rtl/dic_pkg.sv
// Shared constants and carriers for the digital input conditioning block.
// Assumes a 10 MHz system clock and an APB slave with a 12-bit byte address.
package dic_pkg;
    // Clock and sampling period
    localparam int CLK_PERIOD_NS = 100;
    localparam int SAMPLE_PERIOD_NS = 1000000;
    localparam int TICK_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    // Input counts
    localparam int N_PHYS = 16;
    localparam int N_AUX = 7;
    localparam int N_SRC = N_PHYS + N_AUX;

    // Register byte offsets
    localparam logic [11:0] OFS_GATE = 12'h000;
    localparam logic [11:0] OFS_INVERT = 12'h004;
    localparam logic [11:0] OFS_OVR_SEL = 12'h008;
    localparam logic [11:0] OFS_OVR_LVL = 12'h00c;
    localparam logic [11:0] OFS_RAW = 12'h010;
    localparam logic [11:0] OFS_THRESH = 12'h014;
    localparam logic [11:0] OFS_DIFF = 12'h018;
    localparam logic [11:0] OFS_ROUTE_EN = 12'h01c;
    localparam logic [11:0] OFS_SUMMARY = 12'h020;
    localparam logic [4:0] OFS_TABLE_HI = 5'h01;

    // Reset values
    localparam logic [15:0] RST_MASK16 = 16'h0000;
    localparam logic [7:0] RST_ROUTE_CODE = 8'h00;

    // Special function bit positions
    localparam int SF_NEG_LIMIT = 0;
    localparam int SF_POS_LIMIT = 1;
    localparam int SF_HOME = 2;
    localparam int SF_INTERLOCK = 3;
    localparam int N_SF = 4;
    localparam int IN_DIR = 4;
    localparam int IN_CLK = 5;

    // Routing source codes
    localparam logic [6:0] RT_PHYS_LO = 7'h01;
    localparam logic [6:0] RT_PHYS_HI = 7'h10;
    localparam logic [6:0] RT_AUX_LO = 7'h41;
    localparam logic [6:0] RT_AUX_HI = 7'h47;
    localparam int RT_INV_BIT = 7;

    // Register selector
    typedef enum logic [3:0] {
        DIC_R_GATE, DIC_R_INV, DIC_R_OSEL, DIC_R_OLVL, DIC_R_RAW,
        DIC_R_THR, DIC_R_DIFF, DIC_R_ROUTE, DIC_R_SUM, DIC_R_TAB, DIC_R_NONE
    } dic_reg_e;

    // Software configuration carrier
    typedef struct packed {
        logic [15:0] gate;
        logic [15:0] inv;
        logic [15:0] osel;
        logic [15:0] olvl;
        logic thr;
        logic diff;
        logic route;
    } dic_cfg_s;
endpackage : dic_pkg

// >>> rtl/dic_sampler.sv
// Input synchroniser and millisecond sampling filter.
// Assumes asynchronous pins; emits a tick every sample period.
module dic_sampler #(
    parameter int W = 23,
    parameter int TICK_CYC = 10000
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Pins and filtered levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] lvl_out,
    output logic tick_out
);
    logic [W-1:0] s1_q, s2_q, s3_q, sync_q, smp_q, lvl_q;
    logic [15:0] cnt_q;
    logic tick_q;

    // Three stage synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++)
            begin
                if (s2_q[i] == s3_q[i])
                    sync_q[i] <= s3_q[i];
            end
        end
    end

    // Sample period counter
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (cnt_q == 16'(TICK_CYC - 1));
            cnt_q <= (cnt_q == 16'(TICK_CYC - 1)) ? '0 : cnt_q + 16'h0001;
        end
    end

    // two tick agreement
    // A level must hold across two ticks, so pulses under one period never pass
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            smp_q <= '0;
            lvl_q <= '0;
        end
        else if (tick_q)
        begin
            smp_q <= sync_q;
            lvl_q <= lvl_q ^ ((sync_q ^ lvl_q) & ~(sync_q ^ smp_q));
        end
    end

    assign lvl_out = lvl_q;
    assign tick_out = tick_q;

    a_filter_on_tick: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (lvl_q != $past(lvl_q)) |-> $past(tick_q))
        else $error("Filtered level moved off a tick");
    a_filter_two_ticks: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (lvl_q != $past(lvl_q)) |->
        (((lvl_q ^ $past(lvl_q)) & ((lvl_q ^ $past(smp_q)) | (lvl_q ^ smp_q))) == '0))
        else $error("Filtered level took a one-sample glitch");
endmodule : dic_sampler

// >>> rtl/dic_route_mem.sv
// Routing table: one source code per summary bit, two registered read ports.
// Port A serves the routing scan, port B serves bus reads.
module dic_route_mem (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Write port
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read ports
    input wire logic [4:0] rda_addr,
    output logic [7:0] rda_data,
    input wire logic [4:0] rdb_addr,
    output logic [7:0] rdb_data
);
    logic [7:0] mem_q [32];
    logic [7:0] rda_q, rdb_q;

    // Storage; reset routes every bit to the constant zero source
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 32; i++)
                mem_q[i] <= dic_pkg::RST_ROUTE_CODE;
        end
        else if (wr_en)
            mem_q[wr_addr] <= wr_data;
    end

    // Registered reads
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rda_q <= dic_pkg::RST_ROUTE_CODE;
            rdb_q <= dic_pkg::RST_ROUTE_CODE;
        end
        else
        begin
            rda_q <= mem_q[rda_addr];
            rdb_q <= mem_q[rdb_addr];
        end
    end

    assign rda_data = rda_q;
    assign rdb_data = rdb_q;
endmodule : dic_route_mem

// >>> rtl/dic_top.sv
// Digital input conditioning: sampling, forcing, inversion, special function
// gating, routing and the 32-bit input summary word, behind an APB slave.
// Assumes asynchronous input pins and a zero wait state APB master.
//
// Behaviour
// - Inputs sampled every millisecond; changes shorter than one millisecond ignored
// - Each input owns a special bit in 0..15 and a level bit in 16..31; here only inputs one to four drive bits 0..3, bits 4..15 read 0
// - Level bit reflects input status regardless of special function enable
// - Bit 16 holds processed input one; bit 0 is its negative limit
// - Special enable gates the function only and never touches bits 16..31
// - Enable bits: 0 negative limit, 1 positive limit, 2 home, 3 interlock
// - Inversion bit per input makes high read as 0 when set
// - Inversion covers levels and special functions, not clock and direction
// - Force enable substitutes a software value for the sampled level
// - Force value bit supplies the level where force enable bit is set
// - Raw word shows sampled levels without inversion, forcing or gating
// - Threshold select: 0 gives 5 V, 1 gives 24 V, shared inputs
// - Routing enable at 1 assigns a chosen source to each summary bit
// - While routing, gate, invert and force settings have no effect; force still drives the clock and direction levels
// - Code 0 is zero, 1..16 inputs; adding 0x80 inverts the source
//
// Our own choices: the APB interface to the registers and the register addresses.
module dic_top #(
    parameter int TICK_CYC = dic_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Input pins
    input wire logic [15:0] in_pin,
    input wire logic [6:0] aux_pin,
    // Results
    output logic [31:0] summary_word,
    output logic step_clk_lvl,
    output logic step_dir_lvl,
    output logic thresh_24v_sel,
    output logic diff_mode_sel,
    output logic neg_input_en
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    dic_pkg::dic_cfg_s cfg_q;
    logic [dic_pkg::N_SRC-1:0] filt;
    logic tick;
    logic [15:0] forced, lvl_proc;
    logic [31:0] norm_word, summary_q, route_sum_q, rd_q;
    logic [1:0] step_q;
    logic [4:0] scan_q, scan_d1_q;
    logic scan_vld_q, rd_tab_q, rd_err_q;
    logic [7:0] code_a, code_b;
    logic acc, wr;
    dic_pkg::dic_reg_e sel_w, sel_r;

    // Address decode shared by reads and writes
    function automatic dic_pkg::dic_reg_e dic_decode(input logic [11:0] a);
        dic_decode = dic_pkg::DIC_R_NONE;
        if (a[11:7] == dic_pkg::OFS_TABLE_HI && a[1:0] == 2'b00)
            dic_decode = dic_pkg::DIC_R_TAB;
        else
        begin
            case (a)
                dic_pkg::OFS_GATE: dic_decode = dic_pkg::DIC_R_GATE;
                dic_pkg::OFS_INVERT: dic_decode = dic_pkg::DIC_R_INV;
                dic_pkg::OFS_OVR_SEL: dic_decode = dic_pkg::DIC_R_OSEL;
                dic_pkg::OFS_OVR_LVL: dic_decode = dic_pkg::DIC_R_OLVL;
                dic_pkg::OFS_RAW: dic_decode = dic_pkg::DIC_R_RAW;
                dic_pkg::OFS_THRESH: dic_decode = dic_pkg::DIC_R_THR;
                dic_pkg::OFS_DIFF: dic_decode = dic_pkg::DIC_R_DIFF;
                dic_pkg::OFS_ROUTE_EN: dic_decode = dic_pkg::DIC_R_ROUTE;
                dic_pkg::OFS_SUMMARY: dic_decode = dic_pkg::DIC_R_SUM;
                default: dic_decode = dic_pkg::DIC_R_NONE;
            endcase
        end
    endfunction : dic_decode

    // Routing source lookup; unlisted codes behave as the zero source
    function automatic logic dic_route_bit(input logic [7:0] code, input logic [dic_pkg::N_SRC-1:0] src);
        logic [6:0] s;
        logic b;
        s = code[6:0];
        b = 1'b0;
        if (s >= dic_pkg::RT_PHYS_LO && s <= dic_pkg::RT_PHYS_HI)
            b = src[4'(s - dic_pkg::RT_PHYS_LO)];
        else if (s >= dic_pkg::RT_AUX_LO && s <= dic_pkg::RT_AUX_HI)
            b = src[5'(s - dic_pkg::RT_AUX_LO) + 5'd16];
        dic_route_bit = b ^ code[dic_pkg::RT_INV_BIT];
    endfunction : dic_route_bit

    dic_sampler #(
        .W(dic_pkg::N_SRC),
        .TICK_CYC(TICK_CYC)
    ) u_sampler (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in({aux_pin, in_pin}),
        .lvl_out(filt),
        .tick_out(tick)
    );

    // APB handshake: every access completes in its first access cycle
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign sel_w = dic_decode(paddr);
    assign sel_r = sel_w;
    assign pready = acc;
    assign pslverr = acc & rd_err_q;

    dic_route_mem u_route_mem (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr_en(wr && sel_w == dic_pkg::DIC_R_TAB),
        .wr_addr(paddr[6:2]),
        .wr_data(pwdata[7:0]),
        .rda_addr(scan_q),
        .rda_data(code_a),
        .rdb_addr(paddr[6:2]),
        .rdb_data(code_b)
    );

    // Configuration writes; read-only offsets ignore writes
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cfg_q.gate <= dic_pkg::RST_MASK16;
            cfg_q.inv <= dic_pkg::RST_MASK16;
            cfg_q.osel <= dic_pkg::RST_MASK16;
            cfg_q.olvl <= dic_pkg::RST_MASK16;
            cfg_q.thr <= 1'b0;
            cfg_q.diff <= 1'b0;
            cfg_q.route <= 1'b0;
        end
        else if (wr)
        begin
            case (sel_w)
                dic_pkg::DIC_R_GATE: cfg_q.gate <= pwdata[15:0];
                dic_pkg::DIC_R_INV: cfg_q.inv <= pwdata[15:0];
                dic_pkg::DIC_R_OSEL: cfg_q.osel <= pwdata[15:0];
                dic_pkg::DIC_R_OLVL: cfg_q.olvl <= pwdata[15:0];
                dic_pkg::DIC_R_THR: cfg_q.thr <= pwdata[0];
                dic_pkg::DIC_R_DIFF: cfg_q.diff <= pwdata[0];
                dic_pkg::DIC_R_ROUTE: cfg_q.route <= pwdata[0];
                default: ;
            endcase
        end
    end

    // Read data captured in the setup phase, served in the access phase
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rd_q <= '0;
            rd_tab_q <= 1'b0;
            rd_err_q <= 1'b0;
        end
        else if (psel && !penable)
        begin
            rd_tab_q <= (sel_r == dic_pkg::DIC_R_TAB);
            rd_err_q <= (sel_r == dic_pkg::DIC_R_NONE);
            case (sel_r)
                dic_pkg::DIC_R_GATE: rd_q <= {16'h0000, cfg_q.gate};
                dic_pkg::DIC_R_INV: rd_q <= {16'h0000, cfg_q.inv};
                dic_pkg::DIC_R_OSEL: rd_q <= {16'h0000, cfg_q.osel};
                dic_pkg::DIC_R_OLVL: rd_q <= {16'h0000, cfg_q.olvl};
                dic_pkg::DIC_R_RAW: rd_q <= {16'h0000, filt[15:0]};
                dic_pkg::DIC_R_THR: rd_q <= {31'h00000000, cfg_q.thr};
                dic_pkg::DIC_R_DIFF: rd_q <= {31'h00000000, cfg_q.diff};
                dic_pkg::DIC_R_ROUTE: rd_q <= {31'h00000000, cfg_q.route};
                dic_pkg::DIC_R_SUM: rd_q <= summary_q;
                default: rd_q <= '0;
            endcase
        end
    end

    assign prdata = rd_tab_q ? {24'h000000, code_b} : rd_q;

    assign forced = (cfg_q.osel & cfg_q.olvl) | (~cfg_q.osel & filt[15:0]);
    assign lvl_proc = forced ^ cfg_q.inv;

    assign norm_word = {lvl_proc, 12'h000, cfg_q.gate[dic_pkg::N_SF-1:0] & lvl_proc[dic_pkg::N_SF-1:0]};

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            step_q <= 2'b00;
        else
            step_q <= {forced[dic_pkg::IN_CLK], forced[dic_pkg::IN_DIR]};
    end

    // routing scan
    // One table entry per cycle, so the whole word refreshes every 32 cycles
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            scan_q <= 5'h00;
            scan_d1_q <= 5'h00;
            scan_vld_q <= 1'b0;
            route_sum_q <= '0;
        end
        else
        begin
            scan_q <= scan_q + 5'h01;
            scan_d1_q <= scan_q;
            scan_vld_q <= 1'b1;
            if (scan_vld_q)
                route_sum_q[scan_d1_q] <= dic_route_bit(code_a, filt);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            summary_q <= '0;
        else
            summary_q <= cfg_q.route ? route_sum_q : norm_word;
    end

    assign summary_word = summary_q;
    assign step_clk_lvl = step_q[1];
    assign step_dir_lvl = step_q[0];
    assign thresh_24v_sel = cfg_q.thr;
    assign diff_mode_sel = cfg_q.diff;
    assign neg_input_en = cfg_q.diff;

    sequence s_cfg_write(logic [11:0] ofs);
        wr && paddr == ofs;
    endsequence

    a_level_ungated: assert property (!cfg_q.route |=> summary_q[31:16] == $past(lvl_proc))
        else $error("Level bits differ from processed levels");
    a_special_gated: assert property (!cfg_q.route |=>
        summary_q[15:0] == {12'h000, $past(cfg_q.gate[3:0]) & $past(lvl_proc[3:0])})
        else $error("Special bits not gated by enable");
    a_force_level: assert property ((!cfg_q.route && cfg_q.osel[0] && !cfg_q.inv[0]) |=>
        summary_q[16] == $past(cfg_q.olvl[0]))
        else $error("Forced value not shown on bit 16");
    a_invert_level: assert property ((!cfg_q.route && !cfg_q.osel[0]) |=>
        summary_q[16] == ($past(filt[0]) ^ $past(cfg_q.inv[0])))
        else $error("Inversion wrong on bit 16");
    a_clkdir_plain: assert property (1'b1 |=> step_clk_lvl == $past(forced[5])
        && step_dir_lvl == $past(forced[4]))
        else $error("Clock or direction level was inverted");
    a_route_bypass: assert property (cfg_q.route |=> summary_q == $past(route_sum_q))
        else $error("Summary not from routing in routing mode");
    a_route_const: assert property ((scan_vld_q && code_a == 8'h80) |=> route_sum_q[$past(scan_d1_q)])
        else $error("Code 0x80 did not give one");
    a_thresh_write: assert property (s_cfg_write(dic_pkg::OFS_THRESH) |=>
        thresh_24v_sel == $past(pwdata[0]))
        else $error("Threshold select not taken");
    a_diff_write: assert property (s_cfg_write(dic_pkg::OFS_DIFF) |=>
        neg_input_en == $past(pwdata[0]) && diff_mode_sel == $past(pwdata[0]))
        else $error("Differential select not taken");
    a_raw_read: assert property ((psel && !penable && !pwrite && paddr == dic_pkg::OFS_RAW) |=>
        prdata == {16'h0000, $past(filt[15:0])})
        else $error("Raw read mismatch");

    // Read setup phase, answered in the following access cycle
    sequence s_rd_setup(logic [11:0] ofs);
        psel && !penable && !pwrite && paddr == ofs;
    endsequence

    a_summary_read: assert property (s_rd_setup(dic_pkg::OFS_SUMMARY) |=>
        prdata == $past(summary_q) && !pslverr)
        else $error("Summary read mismatch");
    a_gate_write: assert property (s_cfg_write(dic_pkg::OFS_GATE) |=>
        cfg_q.gate == $past(pwdata[15:0]))
        else $error("Special enable write not taken");
    a_route_write: assert property (s_cfg_write(dic_pkg::OFS_ROUTE_EN) |=>
        cfg_q.route == $past(pwdata[0]))
        else $error("Routing enable write not taken");
    a_step_forced: assert property (cfg_q.osel[dic_pkg::IN_CLK] |=>
        step_clk_lvl == $past(cfg_q.olvl[dic_pkg::IN_CLK]))
        else $error("Forced value not applied to clock level");
    a_special_high: assert property (!cfg_q.route |=> summary_q[15:4] == 12'h000)
        else $error("Unused special bits were set");
endmodule : dic_top

// >>> tb/dic_pin_model.sv
// Behavioural model of the switches and sensors on the input pins.
// Assumes the bench sets steady levels and asks for a short glitch now and then.
module dic_pin_model #(
    parameter int GLITCH_CYC = 5
) (
    // Clock
    input wire logic clk_sys,
    // Commands from the bench
    input wire logic [22:0] lvl_set,
    input wire logic glitch_go,
    // Pins
    output logic [15:0] in_pin,
    output logic [6:0] aux_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int glitch_n = 0;

    // Glitch length comes from the bench; it must stay under one sample period
    always @(posedge clk_sys)
    begin
        if (glitch_go)
            glitch_n <= GLITCH_CYC;
        else if (glitch_n > 0)
            glitch_n <= glitch_n - 1;
    end

    // Contact bounce is shown on input one only
    always_comb
    begin
        {aux_pin, in_pin} = lvl_set;
        if (glitch_n > 0)
            in_pin[0] = ~lvl_set[0];
    end
endmodule : dic_pin_model

// >>> tb/tb_top.sv
// Self-checking bench for the input conditioning block.
// Assumes a short sample period parameter so that pin changes settle quickly.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 20;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, summary_word, rd, e;
    logic pready, pslverr, err, step_clk_lvl, step_dir_lvl, thresh_24v_sel, diff_mode_sel, neg_input_en;
    logic [15:0] in_pin, f;
    logic [6:0] aux_pin;
    logic [22:0] lvl_set = 23'h000000;
    logic glitch_go = 1'b0;
    logic [15:0] m_gate = 16'h0000, m_inv = 16'h0000, m_osel = 16'h0000, m_olvl = 16'h0000;
    logic [7:0] m_tab [32];
    int num_errors = 0;
    int cmp_count = 0;
    integer seed = 32'h367d28dc;

    // Clock of 100 ns period
    always #50 clk_sys = ~clk_sys;

    dic_top #(.TICK_CYC(TK)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_pin(in_pin), .aux_pin(aux_pin), .summary_word(summary_word),
        .step_clk_lvl(step_clk_lvl), .step_dir_lvl(step_dir_lvl), .thresh_24v_sel(thresh_24v_sel),
        .diff_mode_sel(diff_mode_sel), .neg_input_en(neg_input_en));

    dic_pin_model #(.GLITCH_CYC(TK - 1)) pins (.clk_sys(clk_sys), .lvl_set(lvl_set), .glitch_go(glitch_go),
        .in_pin(in_pin),
        .aux_pin(aux_pin));

    // Reference: force first, then inversion
    function automatic logic [31:0] exp_norm();
        logic [15:0] l;
        l = ((m_osel & m_olvl) | (~m_osel & lvl_set[15:0])) ^ m_inv;
        return {l, 12'h000, m_gate[3:0] & l[3:0]};
    endfunction : exp_norm

    // Reference value of one routing source; unlisted codes act as the zero source
    function automatic logic src_of(input logic [7:0] c);
        int n;
        logic v;
        n = int'(c[6:0]);
        v = 1'b0;
        if (n >= 1 && n <= 16)
            v = lvl_set[n - 1];
        else if (n >= 'h41 && n <= 'h47)
            v = lvl_set[n - 'h41 + 16];
        return v ^ c[7];
    endfunction : src_of

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("mismatches %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // One APB transfer; the wait for pready is bounded
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            num_errors++;
            end_sim();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // Enough for sync flops plus two sample ticks
    task automatic settle();
        repeat (3 * TK + 10) @(posedge clk_sys);
    endtask : settle

    // Random pins and settings, then every result against the reference
    task automatic norm_round();
        lvl_set <= 23'($random(seed));
        m_gate = 16'($random(seed));
        m_inv = 16'($random(seed));
        m_osel = 16'($random(seed));
        m_olvl = 16'($random(seed));
        apb(1'b1, dic_pkg::OFS_GATE, {16'($random(seed)), m_gate});
        apb(1'b1, dic_pkg::OFS_INVERT, {16'h0000, m_inv});
        apb(1'b1, dic_pkg::OFS_OVR_SEL, {16'h0000, m_osel});
        apb(1'b1, dic_pkg::OFS_OVR_LVL, {16'h0000, m_olvl});
        settle();
        f = (m_osel & m_olvl) | (~m_osel & lvl_set[15:0]);
        chk(summary_word, exp_norm());
        apb(1'b0, dic_pkg::OFS_SUMMARY, 32'h00000000);
        chk(rd, exp_norm());
        chk({31'h0, err}, 32'h00000000);
        apb(1'b0, dic_pkg::OFS_RAW, 32'h00000000);
        chk(rd & 32'h0000ffff, {16'h0000, lvl_set[15:0]});
        chk({30'h0, step_clk_lvl, step_dir_lvl}, {30'h0, f[5], f[4]});
    endtask : norm_round

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // Registers and summary come up cleared
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, 12'(4 * i), 32'h00000000);
            chk(rd, 32'h00000000);
        end
        // Unmapped and misaligned places answer with an error
        apb(1'b0, 12'h040, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        apb(1'b1, 12'h002, 32'hffffffff);
        chk({31'h0, err}, 32'h00000001);
        apb(1'b1, dic_pkg::OFS_RAW, 32'hffffffff);
        apb(1'b0, dic_pkg::OFS_RAW, 32'h00000000);
        chk(rd, 32'h00000000);
        // Threshold and input mode selects, both values
        for (int v = 0; v < 2; v++)
        begin
            apb(1'b1, dic_pkg::OFS_THRESH, {31'($random(seed)), v[0]});
            apb(1'b1, dic_pkg::OFS_DIFF, {31'($random(seed)), v[0]});
            repeat (2) @(posedge clk_sys);
            chk({29'h0, thresh_24v_sel, diff_mode_sel, neg_input_en}, {29'h0, {3{v[0]}}});
            apb(1'b0, dic_pkg::OFS_DIFF, 32'h00000000);
            chk(rd, {31'h0, v[0]});
        end
        for (int r = 0; r < 6; r++)
            norm_round();
        // Pulses just under a sample period, at two phases, never show in any cycle
        for (int g = 0; g < 2; g++)
        begin
            repeat (7 * g + 1) @(posedge clk_sys);
            glitch_go <= 1'b1;
            @(posedge clk_sys);
            glitch_go <= 1'b0;
            repeat (3 * TK + 10)
            begin
                @(posedge clk_sys);
                chk(summary_word, exp_norm());
            end
        end
        // Routing: every source code at least once, plain and inverted
        apb(1'b1, dic_pkg::OFS_ROUTE_EN, 32'h00000001);
        for (int r = 0; r < 2; r++)
        begin
            for (int k = 0; k < 32; k++)
            begin
                int j;
                j = (k + 32 * r) % 24;
                m_tab[k] = (j < 17) ? 8'(j) : 8'(j + 'h30);
                m_tab[k][7] = 1'(((k + 32 * r) / 24) % 2);
                apb(1'b1, 12'h080 + 12'(4 * k), {24'h000000, m_tab[k]});
            end
            // Settings written now must stay without effect
            apb(1'b1, dic_pkg::OFS_INVERT, 32'h0000ffff);
            apb(1'b1, dic_pkg::OFS_OVR_SEL, 32'h0000ffff);
            m_inv = 16'hffff;
            m_osel = 16'hffff;
            repeat (40) @(posedge clk_sys);
            for (int k = 0; k < 32; k++)
                e[k] = src_of(m_tab[k]);
            chk(summary_word, e);
            apb(1'b0, 12'h094, 32'h00000000);
            chk(rd, {24'h000000, m_tab[5]});
        end
        // Leaving routing brings the conditioned word back
        apb(1'b1, dic_pkg::OFS_ROUTE_EN, 32'h00000000);
        repeat (4) @(posedge clk_sys);
        chk(summary_word, exp_norm());
        norm_round();
        end_sim();
    end
endmodule : tb_top
